// File: src/ofs_supervisor.sv
// Output fault supervisor: power-good, crowbar, PWM states, hiccup retry and register slave
//
// What this block does
// - Output-ok low in shutdown, rises above threshold.
// - Output-ok falls only on disable or fault.
// - Under-voltage compares sensed plus 350mV to reference.
// - Soft-start raises output-ok only without overcurrent.
// - Under-voltage drops output-ok, switching continues.
// - Disabled: output-ok holds until output decays.
// - Over-voltage limit drops output-ok immediately.
// - Over-voltage forces PWM low, then high-impedance.
// - Recurring over-voltage forces PWM low again.
// - Over-voltage raises the crowbar drive.
// - Over-voltage locks out PWM until reset.
// - Only enable or supply fall clears lockout.
// - Average current above reference trips shutdown.
// - Overcurrent: PWM high-impedance, wait 2048, restart.
// - Overcurrent in soft-start restarts the wait.
// - Eighth failed attempt latches off.
// - Only enable or supply fall clears latch-off.
// - Successful soft-start runs, raises flag, clears count.
// - Overcurrent ignored during voltage-code transitions.
// - Interval timed by 11-bit phase-clock counter.
// - Start needs supply, enable, oscillator, valid code.
// - Code transition busy signal sets blanking window.
//
// The implementer's own choices: register access over AXI4-Lite and the address map.
module ofs_supervisor #(
	parameter int PHASES    = ofs_pkg::PHASES,
	parameter int SS_CYCLES = ofs_pkg::SS_CYCLES,
	parameter int RETRY_MAX = ofs_pkg::RETRY_MAX
) (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Phase clock and start conditions
	input  wire logic                          phase_clk_pulse,
	input  wire logic                          por_ok,
	input  wire logic                          enable_above,
	input  wire logic                          oscillator_disable_input,
	input  wire logic [ofs_pkg::CODE_W-1:0]    voltage_code,
	input  wire logic                          vcode_step_busy,
	// Digitised sense values
	input  wire logic [ofs_pkg::LVL_W-1:0]     sensed_output_level,
	input  wire logic [ofs_pkg::LVL_W-1:0]     dac_reference_level,
	input  wire logic [ofs_pkg::CUR_W-1:0]     average_channel_current,
	// Protection outputs
	output logic                               output_ok_flag,
	output logic                               output_ok_oe,
	output logic                               crowbar_drive,
	output logic [2*PHASES-1:0]                pwm_mode,
	// AXI4-Lite write channels
	input  wire logic [11:0]                   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [11:0]                   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);

	localparam logic [ofs_pkg::SS_CNT_W-1:0] SS_LAST   = ofs_pkg::SS_CNT_W'(SS_CYCLES - 1);
	localparam logic [ofs_pkg::RETRY_W-1:0]  RETRY_TOP = ofs_pkg::RETRY_W'(RETRY_MAX);
	localparam int NSYNC = 9;

	// ------------------------------------------------------------
	// Register decode helper
	// ------------------------------------------------------------
	function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offs);
		reg_hit = (addr[11:2] == offs[11:2]);
	endfunction : reg_hit

	// ------------------------------------------------------------
	// Comparators and synchronisation
	// ------------------------------------------------------------
	logic [ofs_pkg::LVL_W:0] uv_sum;
	logic                    low_raw;
	logic                    high_raw;
	logic                    ref_raw;
	logic                    oc_raw;
	logic [NSYNC-1:0]        raw_vec;
	logic [NSYNC-1:0]        syn_vec;
	logic                    low_window_fault;
	logic                    high_window_fault;
	logic                    at_ref;
	logic                    oc_cmp;
	logic                    por_s;
	logic                    en_s;
	logic                    osc_s;
	logic                    code_s;
	logic                    busy_s;

	// Offset keeps the under-voltage threshold tracking the voltage code
	assign uv_sum   = {1'b0, sensed_output_level} + {1'b0, ofs_pkg::UV_OFFSET_MV};
	assign low_raw  = uv_sum < {1'b0, dac_reference_level};
	assign high_raw = sensed_output_level >= ofs_pkg::OV_LIMIT_MV;
	assign ref_raw  = sensed_output_level <= dac_reference_level;
	assign oc_raw   = average_channel_current > ofs_pkg::OC_REF_UA;
	assign raw_vec  = {low_raw, high_raw, ref_raw, oc_raw, por_ok, enable_above,
		oscillator_disable_input, (voltage_code != ofs_pkg::CODE_NO_LOAD), vcode_step_busy};

	// Comparator results settle at arbitrary times, so resample them first
	ofs_sync #(
		.WIDTH (NSYNC)
	) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (raw_vec),
		.sync_out (syn_vec)
	);

	assign {low_window_fault, high_window_fault, at_ref, oc_cmp, por_s, en_s, osc_s, code_s, busy_s} = syn_vec;

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	ofs_pkg::ofs_state_t                 state_ff;
	ofs_pkg::ofs_state_t                 nxt_state;
	logic [ofs_pkg::SS_CNT_W-1:0]        cnt_ff;
	logic [ofs_pkg::SS_CNT_W-1:0]        nxt_cnt;
	logic [ofs_pkg::RETRY_W-1:0]         retry_ff;
	logic [ofs_pkg::RETRY_W-1:0]         nxt_retry;
	logic                                flag_ff;
	logic                                oe_ff;
	logic                                nxt_flag;
	logic                                crowbar_ff;
	logic                                ov_low_ff;
	logic                                nxt_ov_low;
	logic                                run_enable_ff;
	logic                                sup_rst;
	logic                                start_ok;
	logic                                overcurrent_fault;
	logic                                interval_done;
	logic                                fail_last;
	ofs_pkg::ofs_pwm_t                   nxt_pwm;

	// Supervisor reset: enable or supply falling is the only way out of a lockout
	assign sup_rst           = ~por_s | ~en_s;
	assign start_ok          = por_s & en_s & osc_s & code_s & run_enable_ff;
	assign overcurrent_fault = oc_cmp & ~busy_s;
	assign interval_done     = phase_clk_pulse & (cnt_ff == SS_LAST);
	assign fail_last         = (retry_ff == RETRY_TOP);

	// Next state; over-voltage outranks every fault but the supervisor reset
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_retry = retry_ff;
		if (sup_rst)
		begin
			nxt_state = ofs_pkg::ST_SHUT;
			nxt_cnt   = '0;
			nxt_retry = '0;
		end
		else if (high_window_fault)
		begin
			nxt_state = ofs_pkg::ST_OVLK;
		end
		else
		begin
			unique case (state_ff)
				ofs_pkg::ST_SHUT:
				begin
					nxt_cnt = '0;
					if (start_ok)
						nxt_state = ofs_pkg::ST_SOFT;
				end
				ofs_pkg::ST_SOFT:
				begin
					if (!start_ok)
						nxt_state = ofs_pkg::ST_SHUT;
					else if (overcurrent_fault)
					begin
						nxt_cnt   = '0;
						nxt_state = fail_last ? ofs_pkg::ST_LATCH : ofs_pkg::ST_WAIT;
						nxt_retry = fail_last ? retry_ff : retry_ff + 1'b1;
					end
					else if (interval_done)
					begin
						nxt_state = ofs_pkg::ST_RUN;
						nxt_retry = '0;
						nxt_cnt   = '0;
					end
					else if (phase_clk_pulse)
						nxt_cnt = cnt_ff + 1'b1;
				end
				ofs_pkg::ST_RUN:
				begin
					if (!start_ok)
						nxt_state = ofs_pkg::ST_SHUT;
					else if (overcurrent_fault)
					begin
						nxt_cnt   = '0;
						nxt_state = fail_last ? ofs_pkg::ST_LATCH : ofs_pkg::ST_WAIT;
						nxt_retry = fail_last ? retry_ff : retry_ff + 1'b1;
					end
				end
				ofs_pkg::ST_WAIT:
				begin
					if (!start_ok)
						nxt_state = ofs_pkg::ST_SHUT;
					else if (interval_done)
					begin
						nxt_state = ofs_pkg::ST_SOFT;
						nxt_cnt   = '0;
					end
					else if (phase_clk_pulse)
						nxt_cnt = cnt_ff + 1'b1;
				end
				ofs_pkg::ST_LATCH:
				begin
					nxt_state = ofs_pkg::ST_LATCH;
				end
				ofs_pkg::ST_OVLK:
				begin
					nxt_state = ofs_pkg::ST_OVLK;
				end
				default:
				begin
					nxt_state = ofs_pkg::ST_SHUT;
					nxt_cnt   = '0;
				end
			endcase
		end
	end

	// Output-ok: falls only on fault or on disable, and on disable only after decay
	always_comb
	begin
		nxt_flag = 1'b0;
		if (high_window_fault)
			nxt_flag = 1'b0;
		else if (state_ff == ofs_pkg::ST_SHUT)
			nxt_flag = flag_ff & ~low_window_fault;
		else if (state_ff == ofs_pkg::ST_SOFT)
			nxt_flag = ~low_window_fault & ~overcurrent_fault;
		else if (state_ff == ofs_pkg::ST_RUN)
			nxt_flag = ~low_window_fault & ~overcurrent_fault;
		else
			nxt_flag = 1'b0;
	end

	// Over-voltage pulls the phases low until the output is back at the reference
	assign nxt_ov_low = (nxt_state == ofs_pkg::ST_OVLK) &
		(high_window_fault | (ov_low_ff & ~at_ref));

	// Phase command follows the next state so the pins move with the state
	always_comb
	begin
		nxt_pwm = ofs_pkg::PWM_HIZ;
		if (nxt_state == ofs_pkg::ST_SOFT || nxt_state == ofs_pkg::ST_RUN)
			nxt_pwm = ofs_pkg::PWM_RUN;
		else if (nxt_state == ofs_pkg::ST_OVLK)
			nxt_pwm = nxt_ov_low ? ofs_pkg::PWM_LOW : ofs_pkg::PWM_HIZ;
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_ff   <= ofs_pkg::ST_SHUT;
			cnt_ff     <= '0;
			retry_ff   <= '0;
			flag_ff    <= 1'b0;
			oe_ff      <= 1'b1;
			ov_low_ff  <= 1'b0;
			crowbar_ff <= 1'b0;
		end
		else
		begin
			state_ff   <= nxt_state;
			cnt_ff     <= nxt_cnt;
			retry_ff   <= nxt_retry;
			flag_ff    <= nxt_flag;
			oe_ff      <= ~nxt_flag;
			ov_low_ff  <= nxt_ov_low;
			crowbar_ff <= ~sup_rst & (high_window_fault | crowbar_ff);
		end
	end

	// Per-phase command flops
	genvar gp;
	generate
		for (gp = 0; gp < PHASES; gp++)
		begin : g_phase
			logic [1:0] mode_ff;
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					mode_ff <= ofs_pkg::PWM_HIZ;
				else
					mode_ff <= nxt_pwm;
			end
			assign pwm_mode[2*gp +: 2] = mode_ff;
		end
	endgenerate

	// Open-drain pin drives low while the flag is low
	assign output_ok_flag = flag_ff;
	assign output_ok_oe   = oe_ff;
	assign crowbar_drive  = crowbar_ff;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic        awready_ff;
	logic        wready_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;
	logic [11:0] waddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        aw_take;
	logic        w_take;
	logic        wr_fire;
	logic        ar_take;
	logic        wr_ctrl;
	logic        wr_known;
	logic        rd_known;
	logic [31:0] status_word;
	logic [31:0] rd_word;

	// Address and data are taken in either order; response after both
	assign aw_take  = s_axi_awvalid & awready_ff;
	assign w_take   = s_axi_wvalid & wready_ff;
	assign wr_fire  = ~awready_ff & ~wready_ff & ~bvalid_ff;
	assign ar_take  = s_axi_arvalid & arready_ff;
	assign wr_ctrl  = wr_fire & reg_hit(waddr_ff, ofs_pkg::REG_CTRL) & wstrb_ff[0];
	assign wr_known = reg_hit(waddr_ff, ofs_pkg::REG_CTRL) | reg_hit(waddr_ff, ofs_pkg::REG_STATUS) |
		reg_hit(waddr_ff, ofs_pkg::REG_COUNT);
	assign rd_known = reg_hit(s_axi_araddr, ofs_pkg::REG_CTRL) | reg_hit(s_axi_araddr, ofs_pkg::REG_STATUS) |
		reg_hit(s_axi_araddr, ofs_pkg::REG_COUNT);

	// Status word packs the live sequencer state for software
	always_comb
	begin
		status_word = '0;
		status_word[ofs_pkg::ST_STATE_LSB +: 6]              = state_ff;
		status_word[ofs_pkg::ST_RETRY_LSB +: ofs_pkg::RETRY_W] = retry_ff;
		status_word[ofs_pkg::ST_FLAG_BIT]                    = flag_ff;
		status_word[ofs_pkg::ST_CROW_BIT]                    = crowbar_ff;
	end

	assign rd_word = reg_hit(s_axi_araddr, ofs_pkg::REG_CTRL)   ? {31'h0000_0000, run_enable_ff} :
		reg_hit(s_axi_araddr, ofs_pkg::REG_STATUS) ? status_word :
		reg_hit(s_axi_araddr, ofs_pkg::REG_COUNT)  ? {21'h00_0000, cnt_ff} : 32'h0000_0000;

	// Write path
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awready_ff    <= 1'b1;
			wready_ff     <= 1'b1;
			bvalid_ff     <= 1'b0;
			bresp_ff      <= ofs_pkg::RESP_OKAY;
			waddr_ff      <= '0;
			wdata_ff      <= '0;
			wstrb_ff      <= '0;
			run_enable_ff <= ofs_pkg::CTRL_RST[ofs_pkg::CTRL_RUN_BIT];
		end
		else
		begin
			if (aw_take)
			begin
				waddr_ff   <= s_axi_awaddr;
				awready_ff <= 1'b0;
			end
			if (w_take)
			begin
				wdata_ff  <= s_axi_wdata;
				wstrb_ff  <= s_axi_wstrb;
				wready_ff <= 1'b0;
			end
			if (wr_fire)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_known ? ofs_pkg::RESP_OKAY : ofs_pkg::RESP_SLVERR;
			end
			if (wr_ctrl)
				run_enable_ff <= wdata_ff[ofs_pkg::CTRL_RUN_BIT];
			if (bvalid_ff && s_axi_bready)
			begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// Read path, one cycle from address to data
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= ofs_pkg::RESP_OKAY;
			rdata_ff   <= '0;
		end
		else if (ar_take)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= rd_word;
			rresp_ff   <= rd_known ? ofs_pkg::RESP_OKAY : ofs_pkg::RESP_SLVERR;
		end
		else if (rvalid_ff && s_axi_rready)
		begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rdata   = rdata_ff;

endmodule : ofs_supervisor

// File: src/ofs_pkg.sv
// Shared constants and types of the output fault supervisor
package ofs_pkg;

	// ------------------------------------------------------------
	// Sizes and timing counts
	// ------------------------------------------------------------
	localparam int SS_CNT_W  = 11;               // Soft-start and hiccup interval counter width
	localparam int SS_CYCLES = 2048;             // Phase-clock cycles per interval
	localparam int RETRY_W   = 3;                // Failed attempt counter width
	localparam int RETRY_MAX = 7;                // Failures allowed before latch-off
	localparam int LVL_W     = 12;               // Level words, one LSB per millivolt
	localparam int CUR_W     = 8;                // Average current word, one LSB per microampere
	localparam int CODE_W    = 5;                // Voltage code width
	localparam int PHASES    = 2;                // PWM channels

	// ------------------------------------------------------------
	// Comparator thresholds
	// ------------------------------------------------------------
	localparam logic [LVL_W-1:0]  UV_OFFSET_MV = 12'h015E; // 350 mV added to the sensed level
	localparam logic [LVL_W-1:0]  OV_LIMIT_MV  = 12'h0898; // 2200 mV over-voltage limit
	localparam logic [CUR_W-1:0]  OC_REF_UA    = 8'h5A;    // 90 uA reference current
	localparam logic [CODE_W-1:0] CODE_NO_LOAD = 5'h1F;    // Reserved code that forces shutdown

	// ------------------------------------------------------------
	// Register map, byte addresses
	// ------------------------------------------------------------
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_COUNT  = 12'h008;
	localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
	localparam int CTRL_RUN_BIT  = 0;
	localparam int ST_STATE_LSB  = 0;
	localparam int ST_RETRY_LSB  = 8;
	localparam int ST_FLAG_BIT   = 12;
	localparam int ST_CROW_BIT   = 13;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		PWM_LOW = 2'h0,
		PWM_HIZ = 2'h1,
		PWM_RUN = 2'h2
	} ofs_pwm_t;

	typedef enum logic [5:0] {
		ST_SHUT  = 6'h01,
		ST_SOFT  = 6'h02,
		ST_RUN   = 6'h04,
		ST_WAIT  = 6'h08,
		ST_LATCH = 6'h10,
		ST_OVLK  = 6'h20
	} ofs_state_t;

endpackage : ofs_pkg

// File: src/ofs_sync.sv
// Two-flop synchroniser for a group of level signals
module ofs_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] hold_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= '0;
			hold_ff <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			hold_ff <= meta_ff;
		end
	end

	assign sync_out = hold_ff;

endmodule : ofs_sync

// File: tb/ofs_supervisor_checker.sv
// Port-level property checker for the output fault supervisor
module ofs_supervisor_checker #(
	parameter int PHASES = 2
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Inputs watched
	input  wire logic                      por_ok,
	input  wire logic                      enable_above,
	input  wire logic                      vcode_step_busy,
	input  wire logic [ofs_pkg::LVL_W-1:0] sensed_output_level,
	input  wire logic [ofs_pkg::LVL_W-1:0] dac_reference_level,
	input  wire logic [ofs_pkg::CUR_W-1:0] average_channel_current,
	// Outputs watched
	input  wire logic                      output_ok_flag,
	input  wire logic                      output_ok_oe,
	input  wire logic                      crowbar_drive,
	input  wire logic [2*PHASES-1:0]       pwm_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Decoded conditions
	// ------------------------------------------------------------
	logic uv_low;
	logic ov_hi;
	logic oc_hi;
	logic pwm_run;
	logic pwm_low;
	logic sup_ok;

	// Raw decisions; the five-cycle antecedents cover sync latency
	assign uv_low  = ({1'b0, sensed_output_level} + {1'b0, ofs_pkg::UV_OFFSET_MV}) < {1'b0, dac_reference_level};
	assign ov_hi   = sensed_output_level >= ofs_pkg::OV_LIMIT_MV;
	assign oc_hi   = (average_channel_current > ofs_pkg::OC_REF_UA) && !vcode_step_busy;
	assign pwm_run = pwm_mode == {PHASES{2'h2}};
	assign pwm_low = pwm_mode == {(2*PHASES){1'b0}};
	assign sup_ok  = por_ok && enable_above;

	default clocking dcb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_oe_mirror: assert property (output_ok_oe == !output_ok_flag)
		else $error("open-drain enable does not mirror flag");
	a_flag_rise: assert property ($rose(output_ok_flag) |-> pwm_run || $past(pwm_run))
		else $error("flag rose outside soft-start or run");
	a_uv_flag: assert property (uv_low [*5] |-> !output_ok_flag)
		else $error("flag high while below low window");
	a_ov_flag: assert property (ov_hi [*5] |-> !output_ok_flag)
		else $error("flag high during over-voltage");
	a_ov_pwm_low: assert property ((ov_hi && sup_ok) [*5] |-> pwm_low && crowbar_drive)
		else $error("pwm not low or crowbar off during over-voltage");
	a_pwm_legal: assert property (pwm_mode == {PHASES{pwm_mode[1:0]}} && pwm_mode[1:0] != 2'h3)
		else $error("pwm phases differ or use an illegal code");
	a_lock_quiet: assert property (crowbar_drive |-> !pwm_run && !output_ok_flag)
		else $error("switching or flag during lockout");
	a_crow_hold: assert property ($fell(crowbar_drive) |-> !$past(sup_ok, 2) || !$past(sup_ok, 3))
		else $error("crowbar cleared without supervisor reset");
	a_oc_trip: assert property (oc_hi [*5] ##0 pwm_run |-> ##[1:2] !pwm_run)
		else $error("switching continued under overcurrent");
	a_oc_blank: assert property ((pwm_run && vcode_step_busy && sup_ok && !ov_hi) [*5] |=> pwm_run)
		else $error("switching stopped during code transition");

	// Main scenarios reached
	c_ov: cover property (crowbar_drive && pwm_low);
	c_trip: cover property ($fell(pwm_run));
	c_good: cover property ($rose(output_ok_flag));
endmodule : ofs_supervisor_checker

bind ofs_supervisor ofs_supervisor_checker #(.PHASES(PHASES)) i_chk (
	.clk                     (clk),
	.rst_n                   (rst_n),
	.por_ok                  (por_ok),
	.enable_above            (enable_above),
	.vcode_step_busy         (vcode_step_busy),
	.sensed_output_level     (sensed_output_level),
	.dac_reference_level     (dac_reference_level),
	.average_channel_current (average_channel_current),
	.output_ok_flag          (output_ok_flag),
	.output_ok_oe            (output_ok_oe),
	.crowbar_drive           (crowbar_drive),
	.pwm_mode                (pwm_mode)
);

// File: tb/ofs_drv_model.sv
// Far-side model: phase clock source and sensed output level
module ofs_drv_model #(
	parameter int PER = 4
) (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// Level chosen by the bench
	input  wire logic [ofs_pkg::LVL_W-1:0] lvl_set,
	// Toward the supervisor
	output logic                           phase_clk_pulse,
	output logic [ofs_pkg::LVL_W-1:0]      sensed_output_level
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_ff;

	// One-cycle phase pulse every PER cycles; level lags one cycle like a sense path
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= 0;
			phase_clk_pulse <= 1'b0;
			sensed_output_level <= '0;
		end
		else
		begin
			cnt_ff <= (cnt_ff == PER - 1) ? 0 : cnt_ff + 1;
			phase_clk_pulse <= cnt_ff == PER - 1;
			sensed_output_level <= lvl_set;
		end
	end
endmodule : ofs_drv_model

// File: tb/ofs_supervisor_test.sv
// Self-checking bench for the output fault supervisor
module ofs_supervisor_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, por_ok = 1'b0, enable_above = 1'b0, osc_in = 1'b1, busy = 1'b0;
	logic [4:0]  vcode = 5'h00;
	logic [11:0] lvl_set = 12'h0000, awaddr = 12'h000, araddr = 12'h000, sensed, dac_ref = 12'h03E8;
	logic [7:0]  cur = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0000_0000, rd, rdata;
	logic [1:0]  rs, bresp, rresp;
	logic        pulse, flag, oe, crow, awready, wready, bvalid, arready, rvalid;
	logic [3:0]  pwm;
	int          error_cnt = 0, cmp_count = 0, n;

	ofs_drv_model i_far (.clk(clk), .rst_n(rst_n), .lvl_set(lvl_set), .phase_clk_pulse(pulse),
		.sensed_output_level(sensed));
	ofs_supervisor #(.SS_CYCLES(8)) i_dut (.clk(clk), .rst_n(rst_n), .phase_clk_pulse(pulse), .por_ok(por_ok),
		.enable_above(enable_above), .oscillator_disable_input(osc_in), .voltage_code(vcode),
		.vcode_step_busy(busy), .sensed_output_level(sensed), .dac_reference_level(dac_ref),
		.average_channel_current(cur), .output_ok_flag(flag), .output_ok_oe(oe), .crowbar_drive(crow),
		.pwm_mode(pwm), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// 100 MHz clock
	initial
	begin
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// Write: address and data offered together, each released when taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [11:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end
		while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Bounded wait for a pwm code; n returns the cycles spent
	task automatic wait_pwm(input logic [3:0] e);
		n = 0;
		while (pwm !== e && n < 600)
		begin
			@(posedge clk);
			n++;
		end
		chk("pwm", e, pwm);
	endtask : wait_pwm

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// Watchdog: whole sequence needs about 650 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		end_of_test();
	end

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		axi_rd(ofs_pkg::REG_CTRL);
		chk("ctrl", ofs_pkg::CTRL_RST, rd);
		chk("outs", 32'h0000_0025, {flag, oe, crow, pwm});
		axi_rd(12'h0FF0);
		chk("unmapped", ofs_pkg::RESP_SLVERR, rs);
		$display("reset test done");
		@(posedge clk);
		por_ok <= 1'b1;
		enable_above <= 1'b1;
		lvl_set <= 12'h0384;
		wait_pwm(4'hA);
		repeat (40) @(posedge clk);
		axi_rd(ofs_pkg::REG_STATUS);
		chk("run", 32'h0000_1004, rd & 32'h0000_373F);
		lvl_set <= 12'h01F4;
		repeat (6) @(posedge clk);
		chk("uv", 32'h0000_000A, {flag, pwm});
		dac_ref <= 12'h0320;
		repeat (6) @(posedge clk);
		chk("uv back", 32'h0000_001A, {flag, pwm});
		busy <= 1'b1;
		cur <= 8'h5B;
		repeat (8) @(posedge clk);
		chk("blank", 32'h0000_001A, {flag, pwm});
		busy <= 1'b0;
		repeat (6) @(posedge clk);
		chk("trip", 32'h0000_0005, {flag, pwm});
		axi_rd(ofs_pkg::REG_STATUS);
		chk("wait", 32'h0000_0108, rd & 32'h0000_073F);
		cur <= 8'h5A;
		wait_pwm(4'hA);
		chk("hiccup", 32'h1, n > 14 && n < 40);
		repeat (40) @(posedge clk);
		axi_rd(ofs_pkg::REG_STATUS);
		chk("retry clr", 32'h0000_0004, rd & 32'h0000_073F);
		$display("hiccup test done");
		cur <= 8'hFF;
		repeat (400) @(posedge clk);
		axi_rd(ofs_pkg::REG_STATUS);
		chk("latch", 32'h0000_0710, rd & 32'h0000_073F);
		chk("latch pwm", 32'h0000_0005, pwm);
		enable_above <= 1'b0;
		cur <= 8'h00;
		repeat (6) @(posedge clk);
		enable_above <= 1'b1;
		wait_pwm(4'hA);
		axi_rd(ofs_pkg::REG_STATUS);
		chk("cleared", 32'h0000_0002, rd & 32'h0000_073F);
		$display("latch-off test done");
		for (int k = 0; k < 2; k++)
		begin
			@(posedge clk);
			if (k == 0) osc_in <= 1'b0;
			else vcode <= ofs_pkg::CODE_NO_LOAD;
			repeat (6) @(posedge clk);
			chk("stop", 32'h0000_0015, {flag, pwm});
			osc_in <= 1'b1;
			vcode <= 5'h00;
			wait_pwm(4'hA);
		end
		lvl_set <= 12'h08FC;
		repeat (6) @(posedge clk);
		chk("ov", 32'h0000_0010, {flag, crow, pwm});
		lvl_set <= 12'h0320;
		repeat (6) @(posedge clk);
		chk("ov ref", 32'h0000_0015, {flag, crow, pwm});
		lvl_set <= 12'h08FC;
		repeat (6) @(posedge clk);
		chk("ov again", 32'h0000_0010, {flag, crow, pwm});
		lvl_set <= 12'h0384;
		por_ok <= 1'b0;
		repeat (6) @(posedge clk);
		chk("ov clr", 32'h0000_0005, {crow, pwm});
		por_ok <= 1'b1;
		wait_pwm(4'hA);
		axi_wr(ofs_pkg::REG_CTRL, 32'h0000_0000);
		chk("wr resp", ofs_pkg::RESP_OKAY, rs);
		repeat (6) @(posedge clk);
		chk("ctrl stop", 32'h0000_0005, pwm);
		axi_wr(12'h0FF0, 32'h0000_0001);
		chk("wr unmapped", ofs_pkg::RESP_SLVERR, rs);
		$display("protection test done");
		end_of_test();
	end
endmodule : ofs_supervisor_test
